// ---- logic/tts_sched.sv ----
// Transmit PDO scheduler with mapping checker and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tts_sched
   import tts_pkg::*;
#(
   parameter int P_TICK_CYCLES = TICK_CYCLES
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [6:0] node_id_i,
   input wire logic sync_i,
   input wire logic rtr_i,
   input wire logic [10:0] rtr_id_i,
   input wire logic [3:0] app_evt_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [10:0] tx_id_o,
   output logic [1:0] tx_pdo_o,
   output logic [3:0] sample_o,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int TW = $clog2(P_TICK_CYCLES + 1);

   logic [TW-1:0] tick_cnt_q;
   logic tick_q;
   logic [31:0] ident_q [NCH];
   logic [7:0] ttype_q [NCH];
   logic [15:0] inh_q [NCH];
   logic [15:0] evt_q [NCH];
   logic [3:0] cnt_q [NCH];
   logic [5:0] mlen_q [NCH*NMAP];
   logic [15:0] win_q;
   logic [15:0] win_cnt_q;
   logic win_open;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [11:0] araddr_q;
   logic [31:0] mem_rd;
   logic [31:0] rd_val;
   logic rd_err;
   tts_rd_t rd_st_q;
   logic wr_go;
   logic [1:0] wch;
   logic [6:0] woff;
   logic [2:0] wk;
   logic [1:0] rch;
   logic [6:0] roff;
   logic [2:0] rk;
   logic we_id, we_tt, we_inh, we_evt, we_cnt, we_map, we_win;
   logic wr_ok;
   logic [5:0] wlen;
   logic [8:0] msum;
   logic mbad;
   logic [3:0] offer;
   logic [3:0] busy;
   logic [3:0] grant;
   logic [3:0] rtr_hit;

   // Length of a mappable object, zero when not mappable
   function automatic logic [5:0] obj_len(input logic [31:0] e);
      logic [7:0] want;
      want = 8'h00;
      unique case (e[31:16])
         OBJ_DUMMY8: want = (e[15:8] == 8'h00) ? LEN8 : 8'h00;
         OBJ_DUMMY16: want = (e[15:8] == 8'h00) ? LEN16 : 8'h00;
         OBJ_DUMMY32: want = (e[15:8] == 8'h00) ? LEN32 : 8'h00;
         OBJ_DIN: want = (e[15:8] == 8'h01) ? LEN8 : 8'h00;
         OBJ_AIN: want = (e[15:8] != 8'h00 && e[15:8] <= AIN_SUBS) ?
                         LEN16 : 8'h00;
         default: want = 8'h00;
      endcase
      obj_len = (want != 8'h00 && e[7:0] == want) ?
                want[5:0] : 6'h00;
   endfunction

   // Legal transmission types
   function automatic logic tt_legal(input logic [7:0] t);
      tt_legal = (t <= TT_CYC_MAX) || (t == TT_RTR_SYNC) ||
                 (t == TT_RTR_ONLY) || (t == TT_ASYNC);
   endfunction

   // Millisecond time base
   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick_cnt_q == TW'(P_TICK_CYCLES - 1))
      begin
         tick_cnt_q <= '0;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (tick_cnt_q == TW'(P_TICK_CYCLES - 1));
      end
   end

   // Synchronous window after each SYNC, zero means unlimited
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         win_cnt_q <= 16'h0000;
      end
      else if (sync_i)
      begin
         win_cnt_q <= win_q;
      end
      else if (tick_q && win_cnt_q != 16'h0000)
      begin
         win_cnt_q <= win_cnt_q - 16'h0001;
      end
   end
   assign win_open = (win_q == 16'h0000) || (win_cnt_q != 16'h0000);

   // Write decode and validation
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wch = awaddr_q[8:7];
   assign woff = awaddr_q[6:0];
   assign wk = 3'((woff - OFS_MAP0) >> 2);
   assign wlen = obj_len(wdata_q);

   always_comb
   begin
      msum = 9'h000;
      mbad = 1'b0;
      for (int k = 0; k < NMAP; k++)
      begin
         if (4'(k) < wdata_q[3:0])
         begin
            msum = msum + 9'(mlen_q[{wch, 3'(k)}]);
            mbad = mbad || (mlen_q[{wch, 3'(k)}] == 6'h00);
         end
      end
   end

   always_comb
   begin
      we_id = 1'b0;
      we_tt = 1'b0;
      we_inh = 1'b0;
      we_evt = 1'b0;
      we_cnt = 1'b0;
      we_map = 1'b0;
      we_win = 1'b0;
      if (!wr_go || wstrb_q != 4'hF)
      begin
         we_id = 1'b0;
      end
      else if (awaddr_q[GLB_BIT])
      begin
         we_win = (awaddr_q[8:0] == OFS_WIN) &&
                  (wdata_q[31:16] == 16'h0000);
      end
      else
      begin
         unique case (woff)
            OFS_ID: we_id = !wdata_q[ID_EXT_BIT];
            OFS_TT: we_tt = tt_legal(wdata_q[7:0]) &&
                            (wdata_q[31:8] == 24'h00_0000);
            OFS_INH: we_inh = (wdata_q[31:16] == 16'h0000);
            OFS_EVT: we_evt = (wdata_q[31:16] == 16'h0000);
            OFS_CNT: we_cnt = (wdata_q[31:4] == 28'h000_0000) &&
                              (wdata_q[3:0] <= 4'(NMAP)) &&
                              (wdata_q[3:0] == 4'h0 ||
                               (!mbad && msum <= MAP_MAX_BITS));
            default: we_map = (woff >= OFS_MAP0) && (woff <= OFS_MAPN) &&
                              (woff[1:0] == 2'b00) &&
                              (cnt_q[wch] == 4'h0) &&
                              (wlen != 6'h00);
         endcase
      end
   end
   // Subindex 0 and unmapped offsets fall through as refused
   assign wr_ok = we_id || we_tt || we_inh || we_evt ||
                  we_cnt || we_map || we_win;

   // Write address and data channels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_awready <= 1'b1;
         awaddr_q <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_wready <= 1'b1;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response, refusal answers as abort
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Communication parameters per channel
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < NCH; c++)
      begin
         if (rst_i)
         begin
            ident_q[c] <= {21'h00_0000,
                           11'(ID_BASE[c] + 11'(node_id_i))};
            ttype_q[c] <= TT_RESET;
            inh_q[c] <= 16'h0000;
            evt_q[c] <= 16'h0000;
         end
         else if (wch == 2'(c))
         begin
            if (we_id)
            begin
               ident_q[c] <= {wdata_q[31:30], 19'h0_0000,
                              wdata_q[10:0]};
            end
            if (we_tt)
            begin
               ttype_q[c] <= wdata_q[7:0];
            end
            if (we_inh)
            begin
               inh_q[c] <= wdata_q[15:0];
            end
            if (we_evt)
            begin
               evt_q[c] <= wdata_q[15:0];
            end
         end
      end
   end

   // Mapping counts and entry lengths
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            cnt_q[c] <= 4'h0;
         end
         for (int i = 0; i < NCH*NMAP; i++)
         begin
            mlen_q[i] <= 6'h00;
         end
      end
      else
      begin
         if (we_cnt)
         begin
            cnt_q[wch] <= wdata_q[3:0];
         end
         if (we_map)
         begin
            mlen_q[{wch, wk}] <= wlen;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         win_q <= 16'h0000;
      end
      else if (we_win)
      begin
         win_q <= wdata_q[15:0];
      end
   end

   // Mapping entry words
   tts_map_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(we_map),
      .waddr_i({wch, wk}),
      .wdata_i(wdata_q),
      .raddr_i({rch, rk}),
      .rdata_o(mem_rd)
   );

   // Read sequencer
   assign rch = araddr_q[8:7];
   assign roff = araddr_q[6:0];
   assign rk = 3'((roff - OFS_MAP0) >> 2);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (araddr_q[GLB_BIT])
      begin
         if (araddr_q[8:0] == OFS_WIN)
         begin
            rd_val = {16'h0000, win_q};
         end
         else if (araddr_q[8:0] == OFS_STAT)
         begin
            rd_val = {24'h00_0000, busy, offer};
         end
         else
         begin
            rd_err = 1'b1;
         end
      end
      else
      begin
         unique case (roff)
            OFS_NUM: rd_val = NUM_SUB;
            OFS_ID: rd_val = ident_q[rch];
            OFS_TT: rd_val = {24'h00_0000, ttype_q[rch]};
            OFS_INH: rd_val = {16'h0000, inh_q[rch]};
            OFS_EVT: rd_val = {16'h0000, evt_q[rch]};
            OFS_CNT: rd_val = {28'h000_0000, cnt_q[rch]};
            default:
            begin
               rd_err = !((roff >= OFS_MAP0) && (roff <= OFS_MAPN) &&
                          (roff[1:0] == 2'b00));
               rd_val = (!rd_err && mlen_q[{rch, rk}] != 6'h00) ?
                        mem_rd : 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_st_q <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         araddr_q <= 12'h000;
      end
      else
      begin
         unique case (rd_st_q)
            RD_IDLE:
            begin
               if (s_axi_arvalid)
               begin
                  araddr_q <= s_axi_araddr;
                  s_axi_arready <= 1'b0;
                  rd_st_q <= RD_MEM;
               end
            end
            RD_MEM: rd_st_q <= RD_MUX;
            RD_MUX:
            begin
               s_axi_rdata <= rd_val;
               s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
               s_axi_rvalid <= 1'b1;
               rd_st_q <= RD_OUT;
            end
            RD_OUT:
            begin
               if (s_axi_rready)
               begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rd_st_q <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // Channel schedulers
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      assign rtr_hit[c] = rtr_i && (rtr_id_i == ident_q[c][10:0]) &&
                          !ident_q[c][ID_RTR_BIT];
      tts_chan u_ch (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tick_i(tick_q),
         .en_i(!ident_q[c][ID_DIS_BIT]),
         .ttype_i(ttype_q[c]),
         .inh_i(inh_q[c]),
         .evt_i(evt_q[c]),
         .sync_i(sync_i),
         .rtr_i(rtr_hit[c]),
         .app_evt_i(app_evt_i[c]),
         .win_open_i(win_open),
         .grant_i(grant[c]),
         .offer_o(offer[c]),
         .busy_o(busy[c])
      );
   end

   // Fixed priority, lowest channel first
   always_comb
   begin
      grant = 4'h0;
      for (int c = NCH - 1; c >= 0; c--)
      begin
         if (offer[c] && !tx_valid_o)
         begin
            grant = 4'(1 << c);
         end
      end
   end

   // Transmit request held until the controller takes it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_valid_o <= 1'b0;
         tx_id_o <= 11'h000;
         tx_pdo_o <= 2'b00;
      end
      else if (grant != 4'h0)
      begin
         tx_valid_o <= 1'b1;
         for (int c = 0; c < NCH; c++)
         begin
            if (grant[c])
            begin
               tx_id_o <= ident_q[c][10:0];
               tx_pdo_o <= 2'(c);
            end
         end
      end
      else if (tx_ready_i)
      begin
         tx_valid_o <= 1'b0;
      end
   end

   // Data refresh strobes
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < NCH; c++)
      begin
         if (rst_i)
         begin
            sample_o[c] <= 1'b0;
         end
         else if (ttype_q[c] == TT_RTR_SYNC)
         begin
            sample_o[c] <= sync_i && !ident_q[c][ID_DIS_BIT];
         end
         else
         begin
            sample_o[c] <= grant[c];
         end
      end
   end
endmodule
`default_nettype wire

// ---- inc/tts_pkg.sv ----
// Constants and encodings shared by the transmit PDO scheduler
`default_nettype none
package tts_pkg;
   // Clock and time base
   localparam int CLK_HZ = 40_000_000;
   localparam int TIME_BASE_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TIME_BASE_US;
   localparam int INH_UNIT_US = 100;
   localparam int INH_PER_MS = TIME_BASE_US / INH_UNIT_US;
   // Channel and mapping sizes
   localparam int NCH = 4;
   localparam int NMAP = 8;
   localparam logic [8:0] MAP_MAX_BITS = 9'h040;
   localparam logic [31:0] NUM_SUB = 32'h0000_0005;
   localparam logic [10:0] ID_BASE [NCH] = '{11'h180, 11'h280,
                                            11'h380, 11'h480};
   // Identifier word fields
   localparam int ID_DIS_BIT = 31;
   localparam int ID_RTR_BIT = 30;
   localparam int ID_EXT_BIT = 29;
   // Transmission types
   localparam logic [7:0] TT_ACYC = 8'h00;
   localparam logic [7:0] TT_CYC_MAX = 8'hF0;
   localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
   localparam logic [7:0] TT_RTR_ONLY = 8'hFD;
   localparam logic [7:0] TT_UNUSED = 8'hFE;
   localparam logic [7:0] TT_ASYNC = 8'hFF;
   localparam logic [7:0] TT_RESET = 8'hFF;
   // Mapping entry lengths and mappable objects
   localparam logic [7:0] LEN8 = 8'h08;
   localparam logic [7:0] LEN16 = 8'h10;
   localparam logic [7:0] LEN32 = 8'h20;
   localparam logic [15:0] OBJ_DUMMY8 = 16'h0005;
   localparam logic [15:0] OBJ_DUMMY16 = 16'h0006;
   localparam logic [15:0] OBJ_DUMMY32 = 16'h0007;
   localparam logic [15:0] OBJ_DIN = 16'h6000;
   localparam logic [15:0] OBJ_AIN = 16'h6401;
   localparam logic [7:0] AIN_SUBS = 8'h08;
   // Register offsets inside a channel block, stride 0x80
   localparam logic [6:0] OFS_NUM = 7'h00;
   localparam logic [6:0] OFS_ID = 7'h04;
   localparam logic [6:0] OFS_TT = 7'h08;
   localparam logic [6:0] OFS_INH = 7'h0C;
   localparam logic [6:0] OFS_EVT = 7'h14;
   localparam logic [6:0] OFS_CNT = 7'h40;
   localparam logic [6:0] OFS_MAP0 = 7'h44;
   localparam logic [6:0] OFS_MAPN = 7'h60;
   // Global registers, selected by address bit 9
   localparam int GLB_BIT = 9;
   localparam logic [8:0] OFS_WIN = 9'h000;
   localparam logic [8:0] OFS_STAT = 9'h004;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Read sequencer, Gray coded
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_MEM = 2'b01,
      RD_MUX = 2'b11,
      RD_OUT = 2'b10
   } tts_rd_t;
endpackage
`default_nettype wire

// ---- logic/tts_map_mem.sv ----
// Mapping entry storage, 32 words, registered read
`timescale 1ns/1ps
`default_nettype none
module tts_map_mem (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [4:0] waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [4:0] raddr_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem_q [32];

   // Write port
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 32'h0000_0000;
      end
      else
      begin
         rdata_o <= mem_q[raddr_i];
      end
   end
endmodule
`default_nettype wire

// ---- logic/tts_chan.sv ----
// One transmit channel: trigger decode, inhibit and event timers
`timescale 1ns/1ps
`default_nettype none
module tts_chan
   import tts_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic en_i,
   input wire logic [7:0] ttype_i,
   input wire logic [15:0] inh_i,
   input wire logic [15:0] evt_i,
   input wire logic sync_i,
   input wire logic rtr_i,
   input wire logic app_evt_i,
   input wire logic win_open_i,
   input wire logic grant_i,
   output logic offer_o,
   output logic busy_o
);
   logic [7:0] sync_cnt_q;
   logic [13:0] inh_cnt_q;
   logic [15:0] evt_cnt_q;
   logic sync_pend_q;
   logic req_pend_q;
   logic evt_pend_q;
   logic cyc;
   logic hit;
   logic [16:0] inh_sum;
   logic [13:0] inh_ms;

   // Decode of the synchronous trigger
   assign cyc = (ttype_i != TT_ACYC) && (ttype_i <= TT_CYC_MAX);
   assign hit = sync_i && ((ttype_i == TT_ACYC) ||
                (cyc && (sync_cnt_q + 8'h01 >= ttype_i)));
   // Inhibit in 100 us units rounded up to whole ms
   assign inh_sum = 17'(inh_i) + 17'(INH_PER_MS - 1);
   assign inh_ms = 14'(inh_sum / 17'(INH_PER_MS));

   // SYNC counting and synchronous send request
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !en_i)
      begin
         sync_cnt_q <= 8'h00;
         sync_pend_q <= 1'b0;
      end
      else
      begin
         if (sync_i && cyc)
         begin
            sync_cnt_q <= hit ? 8'h00 : sync_cnt_q + 8'h01;
         end
         if (hit)
         begin
            sync_pend_q <= 1'b1;
         end
         else if (grant_i || !win_open_i)
         begin
            sync_pend_q <= 1'b0;
         end
      end
   end

   // Remote request and profile event requests
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !en_i)
      begin
         req_pend_q <= 1'b0;
      end
      else if ((rtr_i && (ttype_i == TT_RTR_SYNC ||
                          ttype_i == TT_RTR_ONLY)) ||
               (app_evt_i && ttype_i == TT_ASYNC))
      begin
         req_pend_q <= 1'b1;
      end
      else if (grant_i)
      begin
         req_pend_q <= 1'b0;
      end
   end

   // Periodic event timer, zero switches it off
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !en_i || evt_i == 16'h0000 || ttype_i != TT_ASYNC)
      begin
         evt_cnt_q <= evt_i;
         evt_pend_q <= 1'b0;
      end
      else if (grant_i && evt_pend_q)
      begin
         evt_cnt_q <= evt_i;
         evt_pend_q <= 1'b0;
      end
      else if (tick_i && evt_cnt_q != 16'h0000)
      begin
         evt_cnt_q <= evt_cnt_q - 16'h0001;
         if (evt_cnt_q == 16'h0001)
         begin
            evt_pend_q <= 1'b1;
         end
      end
   end

   // Inhibit starts at the first attempt, plus one tick for phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         inh_cnt_q <= 14'h0000;
      end
      else if (grant_i)
      begin
         inh_cnt_q <= (inh_ms == 14'h0000) ? 14'h0000 :
                      inh_ms + 14'h0001;
      end
      else if (tick_i && inh_cnt_q != 14'h0000)
      begin
         inh_cnt_q <= inh_cnt_q - 14'h0001;
      end
   end

   // Offer only while enabled and outside the inhibit period
   assign busy_o = (inh_cnt_q != 14'h0000);
   assign offer_o = en_i && !busy_o &&
                    (sync_pend_q || req_pend_q || evt_pend_q);
endmodule
`default_nettype wire

// ---- tb/tts_sched_props.sv ----
// Port checker for the transmit PDO scheduler
`timescale 1ns/1ps
`default_nettype none
module tts_sched_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [10:0] tx_id_o,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Send request and bus answers hold until taken
   property p_th; tx_valid_o && !tx_ready_i |=> tx_valid_o; endproperty
   a_th: assert property (p_th) else $error("send dropped");
   property p_ti; tx_valid_o && !tx_ready_i |=> $stable(tx_id_o); endproperty
   a_ti: assert property (p_ti) else $error("id moved");
   property p_td; tx_valid_o && tx_ready_i |=> !tx_valid_o; endproperty
   a_td: assert property (p_td) else $error("send kept");
   property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bh: assert property (p_bh) else $error("bvalid dropped");
   property p_bd; s_axi_bvalid && s_axi_bready |=> s_axi_awready; endproperty
   a_bd: assert property (p_bd) else $error("awready low");
   property p_rl;
      s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid [*2] ##1 s_axi_rvalid;
   endproperty
   a_rl: assert property (p_rl) else $error("read late");
   property p_rh;
      s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata);
   endproperty
   a_rh: assert property (p_rh) else $error("rdata moved");
   property p_ra; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ra: assert property (p_ra) else $error("arready high");
endmodule
bind tts_sched tts_sched_props chk (.*);
`default_nettype wire

// ---- tb/tts_can_ctl.sv ----
// Bus controller model that takes send requests after random stalls
`timescale 1ns/1ps
`default_nettype none
module tts_can_ctl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o
);
   logic [1:0] stall_q;
   // Lost arbitration stalls up to three cycles
   always_ff @(posedge clk_i)
      if (rst_i || !tx_valid_i || tx_ready_o)
      begin
         tx_ready_o <= 1'b0;
         stall_q <= 2'($urandom_range(3));
      end
      else if (stall_q == 2'h0)
         tx_ready_o <= 1'b1;
      else
         stall_q <= stall_q - 2'h1;
endmodule
`default_nettype wire

// ---- tb/tts_sched_tb.sv ----
// Self-checking bench for the transmit PDO scheduler
`timescale 1ns/1ps
`default_nettype none
module tts_sched_tb
   import tts_pkg::*;
;
   logic clk_i, rst_i, sync_i, rtr_i, tx_ready_i, tx_valid_o;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] tx_pdo_o, s_axi_bresp, s_axi_rresp;
   logic [3:0] app_evt_i, sample_o, s_axi_wstrb;
   logic [6:0] node_id_i;
   logic [10:0] rtr_id_i, tx_id_o;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int failures, n_checks, c;
   tts_sched #(.P_TICK_CYCLES(10)) dut (.*);
   tts_can_ctl peer (.clk_i, .rst_i, .tx_valid_i(tx_valid_o),
                     .tx_ready_o(tx_ready_i));
   // 40 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] id(input int k);
      return {21'h0, ID_BASE[k] + {4'h0, node_id_i}};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One register access, then compare response and read data
   task automatic ax(input bit w, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do
      begin
         @(posedge clk_i);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50);
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n == 50) failures++;
      if (n == 50) finish_test;
      chk(w ? s_axi_bresp : s_axi_rresp, r);
      if (!w) chk(s_axi_rdata, d);
   endtask
   // Wait for a send of channel k, check it, wait until taken
   task automatic txw(input int k);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (!tx_valid_o && n < 99);
      chk(tx_id_o, id(k));
      chk(tx_pdo_o, 32'(k));
      chk(sample_o[k], 1'b1);
      while (tx_valid_o && n < 99) @(posedge clk_i) n++;
      if (n >= 99) failures++;
      if (n >= 99) finish_test;
   endtask
   // Main sequence
   initial
   begin
      {sync_i, rtr_i, rtr_id_i, app_evt_i, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      rst_i = 1'b1;
      failures = 0;
      n_checks = 0;
      c = $urandom(91623);
      node_id_i = 7'($urandom_range(127, 1));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (c = 0; c < 4; c++)
      begin
         ax(0, 12'(c * 128 + 4), id(c), RESP_OKAY);
      end
      ax(0, 12'h000, NUM_SUB, RESP_OKAY);
      ax(1, 12'h000, 32'h0000_0007, RESP_SLVERR);
      ax(1, 12'h008, 32'h0000_00f1, RESP_SLVERR);
      ax(0, 12'h008, 32'h0000_00ff, RESP_OKAY);
      ax(1, 12'h004, id(0) | 32'h2000_0000, RESP_SLVERR);
      c = $urandom_range(3);
      app_evt_i[c] <= 1'b1;
      @(posedge clk_i);
      app_evt_i <= 4'h0;
      txw(c);
      ax(1, 12'h008, 32'h0000_0000, RESP_OKAY);
      sync_i <= 1'b1;
      @(posedge clk_i);
      sync_i <= 1'b0;
      txw(0);
      ax(1, 12'h084, id(1) | 32'h8000_0000, RESP_OKAY);
      ax(1, 12'h088, 32'h0000_00fd, RESP_OKAY);
      ax(1, 12'h084, id(1), RESP_OKAY);
      rtr_id_i <= ID_BASE[1] + {4'h0, node_id_i};
      rtr_i <= 1'b1;
      @(posedge clk_i);
      rtr_i <= 1'b0;
      txw(1);
      // Inhibit changed only while disabled, then two requests back to back
      ax(1, 12'h084, id(1) | 32'h8000_0000, RESP_OKAY);
      ax(1, 12'h08c, 32'h0000_000f, RESP_OKAY);
      ax(1, 12'h084, id(1), RESP_OKAY);
      rtr_i <= 1'b1;
      @(posedge clk_i);
      rtr_i <= 1'b0;
      txw(1);
      rtr_i <= 1'b1;
      @(posedge clk_i);
      rtr_i <= 1'b0;
      ax(0, 12'h204, 32'h0000_0020, RESP_OKAY);
      chk(tx_valid_o, 1'b0);
      txw(1);
      // Type 252 refreshes on SYNC only, type 2 sends on every second SYNC
      ax(1, 12'h008, 32'h0000_00fc, RESP_OKAY);
      ax(1, 12'h188, 32'h0000_0002, RESP_OKAY);
      repeat (2)
      begin
         sync_i <= 1'b1;
         @(posedge clk_i);
         sync_i <= 1'b0;
         @(posedge clk_i);
      end
      chk(sample_o, 4'h1);
      chk(tx_valid_o, 1'b0);
      txw(3);
      ax(1, 12'h140, 32'h0000_0001, RESP_SLVERR);
      ax(1, 12'h144, 32'h1234_0008, RESP_SLVERR);
      ax(1, 12'h144, 32'h6000_0108, RESP_OKAY);
      ax(1, 12'h140, 32'h0000_0001, RESP_OKAY);
      ax(0, 12'h144, 32'h6000_0108, RESP_OKAY);
      finish_test;
   end
endmodule
`default_nettype wire
